// ### cid_pkg.sv
// package for the core interrupt dispatch block: offsets, fields, timing, carriers
package cid_pkg;
    // register indices on the plain register port
    localparam logic [3:0] ADDR_CTRL    = 4'h0; // irq_control_reg
    localparam logic [3:0] ADDR_FLAG_A  = 4'h1; // periph_flag_reg_a
    localparam logic [3:0] ADDR_FLAG_B  = 4'h2; // periph_flag_reg_b
    localparam logic [3:0] ADDR_FLAG_C  = 4'h3; // periph_flag_reg_c
    localparam logic [3:0] ADDR_EN_A    = 4'h4; // periph_enable_regs, a
    localparam logic [3:0] ADDR_EN_B    = 4'h5; // periph_enable_regs, b
    localparam logic [3:0] ADDR_EN_C    = 4'h6; // periph_enable_regs, c
    localparam logic [3:0] ADDR_ISTAT   = 4'h7; // sticky event status
    localparam logic [3:0] ADDR_IMASK   = 4'h8; // event mask
    // control register fields
    localparam int CTRL_GIE_BIT  = 7;           // global_irq_enable
    localparam int CTRL_PERIPHERAL_IRQ_GATE_BIT = 6;           // peripheral_irq_gate
    localparam int CORE_SRC_N    = 3;           // core sources, enables 5:3, flags 2:0
    localparam int CTRL_EN_LSB   = 3;
    // reset values
    localparam logic [7:0] CTRL_RST  = 8'h00;
    localparam logic [7:0] REG_RST   = 8'h00;
    // status register: keep all but the two power-state bits (bits 4 and 3)
    localparam logic [7:0] STATUS_SAVE_MASK = 8'he7;
    // fixed vector address
    localparam logic [14:0] IRQ_VECTOR = 15'h0004;
    // dispatch spends this many instruction cycles in flush after the vector load, taking no accept
    localparam int DISPATCH_CYC = 2;
    // instruction cycle in system clocks
    localparam int INSTR_CLKS   = 4;
    // status bits of the event register
    localparam int EV_TAKEN  = 0;
    localparam int EV_RETURN = 1;
    // critical core context carried between core and shadow copies
    typedef struct packed
    {
        logic [7:0]  work;
        logic [7:0]  status;
        logic [4:0]  bank;
        logic [15:0] fsr0;
        logic [15:0] fsr1;
        logic [6:0]  pc_high;
    } cid_ctx_t;
    // dispatch state
    typedef enum logic [1:0] { ST_RUN, ST_FLUSH, ST_WAKE } cid_state_t;
endpackage : cid_pkg

// ### cid_dispatch.sv
// core interrupt dispatch: flags, enables, gating, vectoring, context save and restore
//
// Design decisions made here: the plain strobed port and the address map.
`timescale 1ns/1ps
// Contract
// - reset leaves all interrupt servicing disabled
// - vector only with global, own, peripheral enables
// - flags set regardless of any enable
// - flags held in control and peripheral registers
// - on event with global enable: flush, clear
// - push pc and save core shadow copies
// - load pc with fixed vector address
// - in handler, events flag but never vector
// - return pops pc, restores shadows, sets enable
// - pending requests serviced when enable returns
// - shadow covers work, status, bank, indirect, pchigh
// - latency three to five instruction cycles; here the vector loads one clock after the accepting boundary
// - after wake, next instruction runs first
module cid_dispatch
#(
    parameter int NSRC = 8                              // sources per peripheral register
)
(
    input  wire logic               i_clock,            // system clock
    input  wire logic               i_rst,              // synchronous reset, active high
    input  wire logic               i_cycle_end,        // pulse: instruction cycle boundary
    input  wire logic [2:0]         i_core_event,       // pulses: timer, pin, change
    input  wire logic [3*NSRC-1:0]  i_periph_event,     // pulses: peripheral events a,b,c
    input  wire logic               i_return_instr,     // pulse: return_from_irq_instr executes
    input  wire logic               i_wake,             // pulse: wake from sleep
    input  wire logic [14:0]        i_pc,               // current program counter
    input  wire cid_pkg::cid_ctx_t  i_ctx,              // live core context
    input  wire logic [14:0]        i_stack_top,        // popped return address
    input  wire logic [3:0]         i_addr,             // register index
    input  wire logic [7:0]         i_wdata,            // register write data
    input  wire logic               i_wr,               // write strobe
    input  wire logic               i_rd,               // read strobe
    output logic [7:0]              o_rdata,            // read data, one cycle later
    output logic                    o_flush,            // pulse: discard prefetched instruction
    output logic                    o_push,             // pulse: push o_push_pc
    output logic [14:0]             o_push_pc,          // address to push
    output logic                    o_pop,              // pulse: pop stack into pc
    output logic                    o_pc_load,          // pulse: load pc with o_pc_value
    output logic [14:0]             o_pc_value,         // new program counter
    output logic                    o_ctx_restore,      // pulse: core takes o_ctx
    output cid_pkg::cid_ctx_t       o_ctx,              // shadow copies
    output logic                    o_irq               // level: unmasked event status set
);
    import cid_pkg::*;

    // registers
    logic [7:0]        ctrl_ff;                         // irq_control_reg
    logic [3*NSRC-1:0] pflag_ff;                        // periph flag regs a,b,c
    logic [3*NSRC-1:0] pen_ff;                          // periph enable regs a,b,c
    logic [1:0]        istat_ff;                        // sticky dispatch events
    logic [1:0]        imask_ff;                        // event mask
    logic [7:0]        rdata_ff;                        // read return
    cid_ctx_t          shadow_ff;                       // shadow copies
    cid_state_t        state_ff;                        // dispatch state
    logic [1:0]        cnt_ff;                          // instruction cycles in dispatch
    logic              wake_hold_ff;                    // one instruction after wake pending
    logic [14:0]       pcload_val_ff;                   // registered pc value
    logic              pcload_ff;                       // registered pc load pulse
    logic              pop_ff;                          // registered pop pulse
    logic              push_ff;                         // registered push pulse
    logic              flush_ff;                        // registered flush pulse
    logic              restore_ff;                      // registered restore pulse
    logic [14:0]       push_pc_ff;                      // registered pushed address
    logic              request;                         // gated pending request
    logic              take;                            // accept the interrupt now
    logic              periph_any;                      // any enabled peripheral flag
    logic              core_any;                        // any enabled core flag
    logic [2:0]        core_flag_set;                   // core flags after hardware set

    // pick a byte out of a packed per-register vector
    function automatic logic [7:0] byte_of(input logic [3*NSRC-1:0] v, input int idx);
        logic [7:0] r;
        r = 8'h00;
        for (int k = 0; k < NSRC && k < 8; k++)
        begin
            r[k] = v[idx*NSRC+k];
        end
        return r;
    endfunction : byte_of

    // pending request: or of flag and enable pairs, each pair anded, peripherals gated, total gated
    always_comb
    begin
        core_any   = |(ctrl_ff[CTRL_EN_LSB +: CORE_SRC_N] & ctrl_ff[CORE_SRC_N-1:0]);
        periph_any = ctrl_ff[CTRL_PERIPHERAL_IRQ_GATE_BIT] & (|(pflag_ff & pen_ff));
        request    = ctrl_ff[CTRL_GIE_BIT] & (core_any | periph_any);
        // taken at an instruction boundary, only while running, never just after wake
        take       = request & i_cycle_end & (state_ff == ST_RUN)
                     & ~wake_hold_ff & ~i_wake;
    end

    // core flags in the control register: hardware set wins over a software write
    always_comb
    begin
        core_flag_set = ctrl_ff[CORE_SRC_N-1:0];
        if (i_wr && i_addr == ADDR_CTRL)
        begin
            core_flag_set = i_wdata[CORE_SRC_N-1:0];
        end
        core_flag_set = core_flag_set | i_core_event;
    end

    // control register: enables, gate, global enable, core flags
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            ctrl_ff <= CTRL_RST;
        end
        else
        begin
            // software write of the enable bits
            if (i_wr && i_addr == ADDR_CTRL)
            begin
                ctrl_ff[7:CORE_SRC_N] <= i_wdata[7:CORE_SRC_N];
            end
            // accept clears global enable, return sets it
            if (take)
            begin
                ctrl_ff[CTRL_GIE_BIT] <= 1'b0;
            end
            else if (i_return_instr)
            begin
                ctrl_ff[CTRL_GIE_BIT] <= 1'b1;
            end
            ctrl_ff[CORE_SRC_N-1:0] <= core_flag_set;
        end
    end

    // peripheral flags and enables
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            pflag_ff <= '0;
            pen_ff   <= '0;
        end
        else
        begin
            for (int r = 0; r < 3; r++)
            begin
                // software write to a flag register
                if (i_wr && i_addr == ADDR_FLAG_A + 4'(r))
                begin
                    pflag_ff[r*NSRC +: NSRC] <= i_wdata[NSRC-1:0] | i_periph_event[r*NSRC +: NSRC];
                end
                // otherwise hardware events only add flags
                else
                begin
                    pflag_ff[r*NSRC +: NSRC] <= pflag_ff[r*NSRC +: NSRC] | i_periph_event[r*NSRC +: NSRC];
                end
                // enable register write
                if (i_wr && i_addr == ADDR_EN_A + 4'(r))
                begin
                    pen_ff[r*NSRC +: NSRC] <= i_wdata[NSRC-1:0];
                end
            end
        end
    end

    // dispatch sequence: flush and vector one clock after accept, then wait
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            state_ff <= ST_RUN;
            cnt_ff   <= 2'h0;
        end
        else
        begin
            case (state_ff)
                // normal execution
                ST_RUN:
                begin
                    if (take)
                    begin
                        state_ff <= ST_FLUSH;
                        cnt_ff   <= 2'h0;
                    end
                end
                // instruction cycles after the vector load in which no accept is taken
                ST_FLUSH:
                begin
                    if (i_cycle_end)
                    begin
                        if (cnt_ff == 2'(DISPATCH_CYC - 1))
                        begin
                            state_ff <= ST_RUN;
                        end
                        cnt_ff <= cnt_ff + 2'h1;
                    end
                end
                default:
                begin
                    state_ff <= ST_RUN;
                end
            endcase
        end
    end

    // after wake, hold off vectoring until the next instruction has run;
    // a wake that lands on a boundary already blocks that boundary itself
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            wake_hold_ff <= 1'b0;
        end
        else if (i_wake)
        begin
            wake_hold_ff <= ~i_cycle_end;
        end
        else if (i_cycle_end)
        begin
            wake_hold_ff <= 1'b0;
        end
    end

    // stack, pc and flush pulses
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            flush_ff      <= 1'b0;
            push_ff       <= 1'b0;
            push_pc_ff    <= 15'h0000;
            pop_ff        <= 1'b0;
            pcload_ff     <= 1'b0;
            pcload_val_ff <= 15'h0000;
            restore_ff    <= 1'b0;
        end
        else
        begin
            flush_ff   <= take;
            push_ff    <= take;
            pop_ff     <= i_return_instr & ~take;
            restore_ff <= i_return_instr & ~take;
            pcload_ff  <= take | (i_return_instr & ~take);
            if (take)
            begin
                push_pc_ff    <= i_pc;
                pcload_val_ff <= IRQ_VECTOR;
            end
            else if (i_return_instr)
            begin
                pcload_val_ff <= i_stack_top;
            end
        end
    end

    // shadow copies of critical context
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            shadow_ff <= '0;
        end
        else if (take)
        begin
            shadow_ff        <= i_ctx;
            shadow_ff.status <= i_ctx.status & STATUS_SAVE_MASK;
        end
    end

    // sticky events with mask, write one to clear, set wins
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            istat_ff <= 2'h0;
            imask_ff <= 2'h0;
        end
        else
        begin
            if (i_wr && i_addr == ADDR_IMASK)
            begin
                imask_ff <= i_wdata[1:0];
            end
            istat_ff <= (istat_ff & ~((i_wr && i_addr == ADDR_ISTAT) ? i_wdata[1:0] : 2'h0))
                        | {i_return_instr & ~take, take};
        end
    end

    // read port, data one cycle after strobe, unmapped reads zero
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            rdata_ff <= 8'h00;
        end
        else if (i_rd)
        begin
            case (i_addr)
                ADDR_CTRL:   rdata_ff <= ctrl_ff;
                ADDR_FLAG_A: rdata_ff <= byte_of(pflag_ff, 0);
                ADDR_FLAG_B: rdata_ff <= byte_of(pflag_ff, 1);
                ADDR_FLAG_C: rdata_ff <= byte_of(pflag_ff, 2);
                ADDR_EN_A:   rdata_ff <= byte_of(pen_ff, 0);
                ADDR_EN_B:   rdata_ff <= byte_of(pen_ff, 1);
                ADDR_EN_C:   rdata_ff <= byte_of(pen_ff, 2);
                ADDR_ISTAT:  rdata_ff <= {6'h00, istat_ff};
                ADDR_IMASK:  rdata_ff <= {6'h00, imask_ff};
                default:     rdata_ff <= 8'h00;
            endcase
        end
        else
        begin
            rdata_ff <= 8'h00;
        end
    end

    // outputs
    assign o_rdata       = rdata_ff;
    assign o_flush       = flush_ff;
    assign o_push        = push_ff;
    assign o_push_pc     = push_pc_ff;
    assign o_pop         = pop_ff;
    assign o_pc_load     = pcload_ff;
    assign o_pc_value    = pcload_val_ff;
    assign o_ctx_restore = restore_ff;
    assign o_ctx         = shadow_ff;
    assign o_irq         = |(istat_ff & imask_ff);

    // checks
    AST_RESET_OFF: assert property (@(posedge i_clock) i_rst |=> !ctrl_ff[CTRL_GIE_BIT])
        else $error("global enable set after reset");
    AST_NO_TAKE_WITHOUT_GIE: assert property (@(posedge i_clock) disable iff (i_rst)
        take |-> ctrl_ff[CTRL_GIE_BIT] && (core_any || periph_any))
        else $error("taken without enables");
    AST_FLAG_SETS: assert property (@(posedge i_clock) disable iff (i_rst)
        i_periph_event[0] |=> pflag_ff[0])
        else $error("peripheral flag not set");
    AST_GIE_CLEAR: assert property (@(posedge i_clock) disable iff (i_rst)
        take |=> !ctrl_ff[CTRL_GIE_BIT] && o_flush)
        else $error("no flush or enable clear");
    AST_PUSH_PC: assert property (@(posedge i_clock) disable iff (i_rst)
        take |=> o_push && o_push_pc == $past(i_pc))
        else $error("pc not pushed");
    AST_VECTOR: assert property (@(posedge i_clock) disable iff (i_rst)
        take |=> o_pc_load && o_pc_value == IRQ_VECTOR)
        else $error("vector not loaded");
    AST_SHADOW_STATUS: assert property (@(posedge i_clock) disable iff (i_rst)
        take |=> o_ctx.status == ($past(i_ctx.status) & STATUS_SAVE_MASK))
        else $error("status shadow wrong");
    AST_NO_NEST: assert property (@(posedge i_clock) disable iff (i_rst)
        !ctrl_ff[CTRL_GIE_BIT] |-> !take)
        else $error("redirect with enable clear");
    AST_RETURN: assert property (@(posedge i_clock) disable iff (i_rst)
        (i_return_instr && !take) |=> ctrl_ff[CTRL_GIE_BIT] && o_pop && o_ctx_restore)
        else $error("return incomplete");
    AST_WAKE_HOLD: assert property (@(posedge i_clock) disable iff (i_rst)
        i_wake |-> !take ##1 !take)
        else $error("vector right after wake");
    COV_TAKE: cover property (@(posedge i_clock) take);
    COV_RETURN: cover property (@(posedge i_clock) i_return_instr);
    COV_PENDING: cover property (@(posedge i_clock) !ctrl_ff[CTRL_GIE_BIT] && (core_any || periph_any));
    COV_WAKE_HOLD: cover property (@(posedge i_clock) wake_hold_ff && request && i_cycle_end);
endmodule : cid_dispatch

// ### cid_core_model.sv
// partner model: core pipeline timing, program counter and hardware stack
`timescale 1ns/1ps
module cid_core_model
(
    input  wire logic          i_clock,      // system clock
    input  wire logic          i_rst,        // synchronous reset, active high
    input  wire logic          i_push,       // push request from dispatch
    input  wire logic [14:0]   i_push_pc,    // address to push
    input  wire logic          i_pop,        // pop request from dispatch
    input  wire logic          i_pc_load,    // load pc request
    input  wire logic [14:0]   i_pc_value,   // new pc value
    output logic               o_cycle_end,  // one pulse per instruction cycle
    output logic [14:0]        o_pc,         // running program counter
    output logic [14:0]        o_stack_top,  // top of hardware stack
    output cid_pkg::cid_ctx_t  o_ctx         // live core context
);
    import cid_pkg::*;
    logic [1:0]  phase_ff;                   // clock phase within an instruction cycle
    logic [14:0] stack_ff [16];              // return address stack
    logic [3:0]  depth_ff;                   // number of stacked addresses
    // context follows the pc, so every save sees fresh values and varying power bits
    assign o_ctx       = {o_pc[7:0], ~o_pc[7:0], o_pc[4:0], {1'b0, o_pc}, {o_pc, 1'b1}, o_pc[14:8]};
    assign o_cycle_end = (phase_ff == 2'h3);
    assign o_stack_top = stack_ff[depth_ff - 4'h1];
    // instruction cycle of four clocks
    always_ff @(posedge i_clock)
    begin
        phase_ff <= i_rst ? 2'h0 : phase_ff + 2'h1;
    end
    // pc follows loads, else steps once per instruction
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
            o_pc <= 15'h0000;
        else if (i_pc_load)
            o_pc <= i_pc_value;
        else if (o_cycle_end)
            o_pc <= o_pc + 15'h0001;
    end
    // stack: push stores the address, pop drops the top
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
            depth_ff <= 4'h0;
        else if (i_push)
        begin
            stack_ff[depth_ff] <= i_push_pc;
            depth_ff           <= depth_ff + 4'h1;
        end
        else if (i_pop)
            depth_ff <= depth_ff - 4'h1;
    end
endmodule : cid_core_model

// ### tb_top.sv
// self-checking testbench of the core interrupt dispatch block
`timescale 1ns/1ps
module tb_top;
    import cid_pkg::*;
    logic i_clock = 1'b0;                     // system clock
    logic i_rst = 1'b1;                       // synchronous reset
    logic wake = 1'b0;                        // wake from sleep pulse
    logic [2:0] core_ev = '0;                 // core event pulses
    logic [23:0] per_ev = '0;                 // peripheral event pulses
    logic ret = 1'b0;                         // return instruction pulse
    logic [3:0] addr = '0;                    // register index
    logic [7:0] wdata = '0;                   // register write data
    logic wr = 1'b0;                          // write strobe
    logic rd = 1'b0;                          // read strobe
    logic [7:0] rdata;
    logic flush, push, pop, pcl, restore, irq, cyc_end;
    logic [14:0] push_pc, pc_value, pc, stk;
    cid_ctx_t ctx_out, ctx_live, ctx_exp;
    logic [15:0] exp_pc[$];                   // bit 15 marks a return to the stack top
    logic [7:0] exp_rd[$];                    // expected read data
    logic rd_d = 1'b0;                        // a read answer is due
    logic [14:0] pc_d, stk_d;                 // inputs seen at the previous edge
    int miscompares = 0;
    int cmp_count = 0;
    int cycles = 0;
    always #4 i_clock = ~i_clock;
    cid_dispatch #(.NSRC(8)) u_dut (.i_clock(i_clock), .i_rst(i_rst), .i_cycle_end(cyc_end),
        .i_core_event(core_ev), .i_periph_event(per_ev), .i_return_instr(ret),
        .i_wake(wake), .i_pc(pc), .i_ctx(ctx_live), .i_stack_top(stk), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_flush(flush),
        .o_push(push), .o_push_pc(push_pc), .o_pop(pop), .o_pc_load(pcl),
        .o_pc_value(pc_value), .o_ctx_restore(restore), .o_ctx(ctx_out), .o_irq(irq));
    cid_core_model u_core (.i_clock(i_clock), .i_rst(i_rst), .i_push(push),
        .i_push_pc(push_pc), .i_pop(pop), .i_pc_load(pcl), .i_pc_value(pc_value),
        .o_cycle_end(cyc_end), .o_pc(pc), .o_stack_top(stk), .o_ctx(ctx_live));
    // shadow expected for a take at pc p: live context of the core, power bits dropped
    function automatic cid_ctx_t shadow_of(input logic [14:0] p);
        return {p[7:0], ~p[7:0] & STATUS_SAVE_MASK, p[4:0], {1'b0, p}, {p, 1'b1}, p[14:8]};
    endfunction : shadow_of
    // compare one value and count it
    task automatic check(input logic [79:0] seen, input logic [79:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // register write, one cycle strobe
    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clock);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge i_clock);
        wr <= 1'b0;
    endtask : reg_wr
    // register read, expected answer queued for the watcher
    task automatic reg_rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge i_clock);
        exp_rd.push_back(e);
        rd <= 1'b1;
        addr <= a;
        @(posedge i_clock);
        rd <= 1'b0;
    endtask : reg_rd
    // one-cycle event or return pulse
    task automatic pulse(input logic [2:0] c, input logic [23:0] p, input logic r);
        @(posedge i_clock);
        core_ev <= c;
        per_ev <= p;
        ret <= r;
        @(posedge i_clock);
        core_ev <= '0;
        per_ev <= '0;
        ret <= 1'b0;
    endtask : pulse
    // wait until every expected redirection was seen, then settle
    task automatic drain();
        for (int i = 0; i < 200 && exp_pc.size() != 0; i++)
            @(posedge i_clock);
        check(exp_pc.size(), 0);
        repeat (12) @(posedge i_clock);
    endtask : drain
    // verdict and end of run
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : complete_run
    // watcher: read answers and every redirection against the oldest note
    always @(posedge i_clock)
    begin
        rd_d <= rd & ~i_rst;
        pc_d <= pc;
        stk_d <= stk;
        if (rd_d)
            check(rdata, exp_rd.pop_front());
        if (pcl === 1'b1 && exp_pc.size() == 0)
            check(pc_value, 15'h7fff);
        else if (pcl === 1'b1 && exp_pc[0][15])
        begin
            void'(exp_pc.pop_front());
            check(pc_value, stk_d);
            check({pop, restore, flush, push}, 4'b1100);
            check(ctx_out, ctx_exp);
        end
        else if (pcl === 1'b1)
        begin
            void'(exp_pc.pop_front());
            ctx_exp = shadow_of(pc_d);
            check(pc_value, IRQ_VECTOR);
            check({flush, push, pop}, 3'b110);
            check(push_pc, pc_d);
            check(ctx_out, ctx_exp);
        end
    end
    // run length guard
    always @(posedge i_clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            complete_run();
        end
    end
    initial
    begin
        logic [7:0] r;
        void'($urandom(32'hc354));
        repeat (2) @(posedge i_clock);
        i_rst <= 1'b0;
        reg_rd(ADDR_CTRL, CTRL_RST);
        reg_rd(ADDR_FLAG_A, REG_RST);
        $display("test reset done");
        r = 8'($urandom);
        reg_wr(ADDR_EN_B, r);
        reg_rd(ADDR_EN_B, r);
        reg_rd(4'hf, 8'h00);
        reg_wr(ADDR_EN_B, 8'h00);
        $display("test register access done");
        // events with every enable clear still set their flags
        pulse(3'b001, 24'h010101, 1'b0);
        reg_rd(ADDR_CTRL, 8'h01);
        reg_rd(ADDR_FLAG_A, 8'h01);
        reg_rd(ADDR_FLAG_B, 8'h01);
        reg_rd(ADDR_FLAG_C, 8'h01);
        reg_wr(ADDR_CTRL, 8'h81);
        reg_wr(ADDR_EN_A, 8'h01);
        repeat (16) @(posedge i_clock);
        exp_pc.push_back(16'h0000);
        reg_wr(ADDR_CTRL, 8'hc1);
        drain();
        reg_rd(ADDR_CTRL, 8'h41);
        $display("test gating and take done");
        // in the handler a new event only flags
        pulse(3'b010, 24'h000000, 1'b0);
        repeat (16) @(posedge i_clock);
        reg_rd(ADDR_CTRL, 8'h43);
        reg_rd(ADDR_ISTAT, 8'h01);
        reg_wr(ADDR_IMASK, 8'h01);
        @(posedge i_clock);
        check(irq, 1'b1);
        reg_wr(ADDR_ISTAT, 8'h01);
        @(posedge i_clock);
        check(irq, 1'b0);
        $display("test handler and status done");
        // return with a flag still set is taken again at once
        exp_pc.push_back(16'h8000);
        exp_pc.push_back(16'h0000);
        pulse(3'b000, 24'h000000, 1'b1);
        drain();
        reg_wr(ADDR_FLAG_A, 8'h00);
        exp_pc.push_back(16'h8000);
        pulse(3'b000, 24'h000000, 1'b1);
        drain();
        reg_rd(ADDR_CTRL, 8'hc3);
        reg_rd(ADDR_ISTAT, 8'h03);
        @(posedge i_clock);
        check(irq, 1'b1);
        $display("test return done");
        // wake one clock before a boundary with a request pending: one instruction first
        do
            @(posedge i_clock);
        while (cyc_end !== 1'b1);
        repeat (2) @(posedge i_clock);
        exp_pc.push_back(16'h0000);
        wake <= 1'b1;
        per_ev <= 24'h000001;
        @(posedge i_clock);
        wake <= 1'b0;
        per_ev <= '0;
        repeat (4) @(posedge i_clock);
        @(negedge i_clock);
        check(exp_pc.size(), 1);
        drain();
        $display("test wake done");
        complete_run();
    end
endmodule : tb_top
